// file: hw/wss_top.sv
/*
  Waveform slot sequencer: register port, start bit and the slot walk.
  Assumes the register port and the waveform engine share SYS_CLK, so
  none of their signals are synchronised. Slots four to seven live in
  neighbouring registers and arrive here as plain inputs.
*/
`timescale 1ns/100ps
module wss_top
  import wss_pkg::*;
(
  input  wire logic             SYS_CLK,
  input  wire logic             RST,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  input  wire logic [7:0]       REG_WDATA,
  output logic [7:0]            REG_RDATA,
  input  wire wss_pkg::wss_id_t EXT_SLOT_FOUR,
  input  wire wss_pkg::wss_id_t EXT_SLOT_FIVE,
  input  wire wss_pkg::wss_id_t EXT_SLOT_SIX,
  input  wire wss_pkg::wss_id_t EXT_SLOT_SEVEN,
  input  wire logic             PLAY_DONE,
  output wss_pkg::wss_id_t      PLAY_ID,
  output logic                  PLAY_REQ,
  output logic                  PLAY_STOP,
  output logic                  SEQ_ACTIVE
);

  // ---------------------------------------------------------------
  // Slot storage
  // ---------------------------------------------------------------
  wss_id_t local_slot [WSS_LOCAL_SLOTS];
  wss_id_t all_slot   [WSS_ALL_SLOTS];

  wss_slot_regs u_slots (
    .clk   (SYS_CLK),
    .rst   (RST),
    .wr    (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .slot  (local_slot)
  );

  // Slot order follows register address order
  // Slots four to seven are owned elsewhere and cannot be read back here
  assign all_slot[0] = local_slot[0];
  assign all_slot[1] = local_slot[1];
  assign all_slot[2] = local_slot[2];
  assign all_slot[3] = local_slot[3];
  assign all_slot[4] = EXT_SLOT_FOUR;
  assign all_slot[5] = EXT_SLOT_FIVE;
  assign all_slot[6] = EXT_SLOT_SIX;
  assign all_slot[7] = EXT_SLOT_SEVEN;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  wss_state_t state_q;
  wss_state_t state_d;
  logic [2:0] idx_q;
  logic [2:0] idx_d;
  logic       go_q;
  logic       go_d;
  wss_id_t    play_id_q;
  wss_id_t    play_id_d;
  logic       play_req_q;
  logic       play_req_d;
  logic       play_stop_q;
  logic       play_stop_d;
  logic [7:0] rdata_q;

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  wire logic       ctrl_wr;
  wire logic       go_wr_one;
  wire logic       go_wr_zero;
  wire wss_id_t    cur_id;
  wire logic       cur_zero;
  wire logic       at_last;
  wire logic [2:0] idx_next;
  wire logic [7:0] ctrl_view;
  wire logic [7:0] rd_mux;

  assign ctrl_wr    = REG_WR && (REG_ADDR == WSS_ADDR_CTRL);
  assign go_wr_one  = ctrl_wr && REG_WDATA[WSS_GO_BIT];
  // Writing zero while running cancels the walk; a trade for a simpler engine
  // is that the waveform in flight is told to stop rather than drained.
  assign go_wr_zero = ctrl_wr && !REG_WDATA[WSS_GO_BIT];
  // Slots are read live, so a later slot rewritten mid walk is what gets played
  assign cur_id     = all_slot[idx_q];
  assign cur_zero   = (cur_id == WSS_ID_NONE);
  assign at_last    = (idx_q == WSS_IDX_LAST);
  assign idx_next   = idx_q + WSS_IDX_STEP;
  // Only the start bit lives here; the other control bits belong to logic outside
  assign ctrl_view  = 8'(go_q);

  assign rd_mux = (REG_ADDR == WSS_ADDR_CTRL)       ? ctrl_view     :
                  (REG_ADDR == WSS_ADDR_SLOT_ZERO)  ? local_slot[0] :
                  (REG_ADDR == WSS_ADDR_SLOT_ONE)   ? local_slot[1] :
                  (REG_ADDR == WSS_ADDR_SLOT_TWO)   ? local_slot[2] :
                  (REG_ADDR == WSS_ADDR_SLOT_THREE) ? local_slot[3] :
                  WSS_READ_ZERO;

  // ---------------------------------------------------------------
  // Sequencer decisions
  // ---------------------------------------------------------------
  wire logic       in_idle;
  wire logic       in_fetch;
  wire logic       in_play;
  wire logic       walk_start;
  wire logic       walk_cancel;
  wire logic       fetch_end;
  wire logic       play_next;
  wire logic       play_final;
  wire logic       walk_ends;
  wire logic       restart;

  assign in_idle     = (state_q == WSS_IDLE);
  assign in_fetch    = (state_q == WSS_FETCH);
  assign in_play     = (state_q == WSS_PLAY);
  assign walk_start  = in_idle && go_wr_one;
  // Cancel is a plain write of zero; it beats a slot ending on the same cycle
  assign walk_cancel = !in_idle && go_wr_zero;
  assign fetch_end   = in_fetch && !go_wr_zero && cur_zero;
  assign play_next   = in_play && !go_wr_zero && PLAY_DONE && !at_last;
  assign play_final  = in_play && !go_wr_zero && PLAY_DONE && at_last;
  assign walk_ends   = fetch_end || play_final;
  // Restart request landing on the final cycle wins over self-clear
  assign restart     = walk_ends && go_wr_one;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    idx_d       = idx_q;
    go_d        = go_q;
    play_id_d   = play_id_q;
    play_req_d  = 1'b0;
    play_stop_d = 1'b0;
    unique case (state_q)
      WSS_IDLE: begin
        if (walk_start) begin
          go_d    = 1'b1;
          idx_d   = WSS_IDX_FIRST;
          state_d = WSS_FETCH;
        end
      end
      WSS_FETCH: begin
        if (walk_cancel) begin
          go_d    = 1'b0;
          state_d = WSS_IDLE;
        end else if (fetch_end) begin
          // Zero ends the walk, including a zero in the very first slot
          go_d    = restart;
          idx_d   = WSS_IDX_FIRST;
          state_d = restart ? WSS_FETCH : WSS_IDLE;
        end else begin
          play_id_d  = cur_id;
          play_req_d = 1'b1;
          state_d    = WSS_PLAY;
        end
      end
      WSS_PLAY: begin
        if (walk_cancel) begin
          go_d        = 1'b0;
          play_stop_d = 1'b1;
          state_d     = WSS_IDLE;
        end else if (play_final) begin
          go_d    = restart;
          idx_d   = WSS_IDX_FIRST;
          state_d = restart ? WSS_FETCH : WSS_IDLE;
        end else if (play_next) begin
          idx_d   = idx_next;
          state_d = WSS_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_q     <= WSS_IDLE;
      idx_q       <= WSS_IDX_FIRST;
      go_q        <= 1'b0;
      play_id_q   <= WSS_ID_NONE;
      play_req_q  <= 1'b0;
      play_stop_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      idx_q       <= idx_d;
      go_q        <= go_d;
      play_id_q   <= play_id_d;
      play_req_q  <= play_req_d;
      play_stop_q <= play_stop_d;
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  // Read data is registered so the port sees a clean one-cycle latency
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= WSS_READ_ZERO;
    end else if (REG_RD) begin
      rdata_q <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign REG_RDATA  = rdata_q;
  assign PLAY_ID    = play_id_q;
  assign PLAY_REQ   = play_req_q;
  assign PLAY_STOP  = play_stop_q;
  assign SEQ_ACTIVE = go_q;

endmodule

// file: common/wss_pkg.sv
/*
  Constants and types shared by the waveform slot sequencer.
  Assumes one clock domain and a byte-wide register port in the same domain.
*/
// What this block does
// - On start, read the slot at 0x03 first and play its identifier.
// - After each of the first seven waveforms ends, move to the next slot address, 0x04 onward.
// - A zero identifier in the fetched slot ends the sequence, nothing played.
// - Each local slot (0x03 to 0x06) is an 8-bit read/write identifier, reset to zero.
// - Start bit stays set while running and clears itself on completion.
package wss_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] WSS_ADDR_CTRL       = 8'h02;
  localparam logic [7:0] WSS_ADDR_SLOT_ZERO  = 8'h03;
  localparam logic [7:0] WSS_ADDR_SLOT_ONE   = 8'h04;
  localparam logic [7:0] WSS_ADDR_SLOT_TWO   = 8'h05;
  localparam logic [7:0] WSS_ADDR_SLOT_THREE = 8'h06;

  localparam int         WSS_GO_BIT     = 0;
  localparam logic [7:0] WSS_SLOT_RESET = 8'h00;
  localparam logic [7:0] WSS_ID_NONE    = 8'h00;
  localparam logic [7:0] WSS_READ_ZERO  = 8'h00;

  // ---------------------------------------------------------------
  // Sequence shape
  // ---------------------------------------------------------------
  localparam int         WSS_LOCAL_SLOTS = 4;
  localparam int         WSS_ALL_SLOTS   = 8;
  localparam logic [2:0] WSS_IDX_FIRST   = 3'h0;
  localparam logic [2:0] WSS_IDX_LAST    = 3'h7;
  localparam logic [2:0] WSS_IDX_STEP    = 3'h1;

  typedef logic [7:0] wss_id_t;

  typedef enum logic [1:0] {
    WSS_IDLE,
    WSS_FETCH,
    WSS_PLAY
  } wss_state_t;

endpackage

// file: hw/wss_slot_regs.sv
/*
  The four local waveform slot registers with their write decode.
  Assumes writes arrive as single-cycle strobes on the device clock.
*/
`timescale 1ns/100ps
module wss_slot_regs
  import wss_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr,
  input  wire logic [7:0]       addr,
  input  wire wss_pkg::wss_id_t wdata,
  output wss_pkg::wss_id_t      slot [WSS_LOCAL_SLOTS]
);

  // ---------------------------------------------------------------
  // Per-slot storage
  // ---------------------------------------------------------------
  localparam logic [7:0] SLOT_ADDR [WSS_LOCAL_SLOTS] = '{
    WSS_ADDR_SLOT_ZERO, WSS_ADDR_SLOT_ONE, WSS_ADDR_SLOT_TWO, WSS_ADDR_SLOT_THREE};

  for (genvar i = 0; i < WSS_LOCAL_SLOTS; i++) begin : g_slot
    wire logic hit;
    wss_id_t   slot_q;
    assign hit = wr && (addr == SLOT_ADDR[i]);
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        slot_q <= WSS_SLOT_RESET;
      end else if (hit) begin
        slot_q <= wdata;
      end
    end
    assign slot[i] = slot_q;
  end

endmodule

// file: bench/wss_seq_properties.sv
/* Port checks for the slot sequencer.
   Assumes it is bound into wss_top and one clock domain. */
`timescale 1ns/100ps
module wss_seq_props
  import wss_pkg::*;
(
  input wire logic             SYS_CLK,
  input wire logic             RST,
  input wire logic [7:0]       REG_ADDR,
  input wire logic             REG_WR,
  input wire logic [7:0]       REG_WDATA,
  input wire logic             PLAY_DONE,
  input wire wss_pkg::wss_id_t PLAY_ID,
  input wire logic             PLAY_REQ,
  input wire logic             PLAY_STOP,
  input wire logic             SEQ_ACTIVE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  wire ctrl_wr = REG_WR && (REG_ADDR == WSS_ADDR_CTRL);
  wire go_wr   = ctrl_wr && REG_WDATA[WSS_GO_BIT];
  logic       wait_q;
  logic [3:0] plays_q;
  // A cancel write ends the wait too, so a stop is never taken for a hang
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wait_q  <= 1'b0;
      plays_q <= 4'h0;
    end else begin
      wait_q  <= PLAY_REQ || (wait_q && !PLAY_DONE && !(ctrl_wr && !go_wr));
      plays_q <= !SEQ_ACTIVE ? 4'h0 : plays_q + {3'h0, PLAY_REQ};
    end
  end
  sequence s_issue;
    PLAY_REQ || !SEQ_ACTIVE;
  endsequence
  AST_START: assert property (go_wr && !SEQ_ACTIVE |=> SEQ_ACTIVE ##1 s_issue)
    else $error("start did not fetch the first slot");
  AST_NEXT: assert property (PLAY_DONE && wait_q && plays_q < 4'h8 && !ctrl_wr |-> ##2 s_issue)
    else $error("no fetch after waveform end");
  AST_NONZERO: assert property (PLAY_REQ |-> PLAY_ID != WSS_ID_NONE)
    else $error("zero identifier played");
  AST_EIGHT: assert property (PLAY_DONE && wait_q && plays_q == 4'h8 && !go_wr |=> !SEQ_ACTIVE ##1 !PLAY_REQ)
    else $error("walk went past eight slots");
  AST_ONE_OUT: assert property (wait_q && !PLAY_DONE |=> !PLAY_REQ)
    else $error("request while a waveform plays");
  AST_STAYS: assert property (wait_q |-> SEQ_ACTIVE)
    else $error("start bit dropped mid walk");
  AST_HOLD_ID: assert property (!PLAY_REQ |-> $stable(PLAY_ID))
    else $error("identifier changed without request");
  AST_CANCEL: assert property (wait_q && ctrl_wr && !go_wr |=> PLAY_STOP && !SEQ_ACTIVE)
    else $error("cancel did not stop the waveform");
endmodule
bind wss_top wss_seq_props u_props (.SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA), .PLAY_DONE(PLAY_DONE), .PLAY_ID(PLAY_ID), .PLAY_REQ(PLAY_REQ), .PLAY_STOP(PLAY_STOP),
  .SEQ_ACTIVE(SEQ_ACTIVE));

// file: bench/wss_engine_model.sv
/* Waveform engine stand-in: ends each waveform lat plus one cycles after its request.
   Assumes lat is at least one; a stop drops the waveform in flight. */
`timescale 1ns/100ps
module wss_engine_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic       stop,
  input  wire logic [7:0] lat,
  output logic            done
);
  logic [7:0] left_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_q <= 8'h00;
      done   <= 1'b0;
    end else begin
      left_q <= req ? lat : ((stop || left_q == 8'h00) ? 8'h00 : left_q - 8'h01);
      done   <= !stop && (left_q == 8'h01);
    end
  end
endmodule

// file: bench/tb.sv
/* Self-checking bench for wss_top with an engine stand-in.
   Assumes inputs change on the falling edge of a 25 MHz clock. */
`timescale 1ns/100ps
module tb;
  import wss_pkg::*;
  logic       SYS_CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, lat = 8'h01;
  wss_id_t    ext [4] = '{default: 8'h00};
  wss_id_t    PLAY_ID;
  logic       PLAY_DONE, PLAY_REQ, PLAY_STOP, SEQ_ACTIVE;
  wss_id_t    ids [$];
  int         mismatches = 0, n_tests = 0;
  always #20 SYS_CLK = ~SYS_CLK;
  always @(negedge SYS_CLK) if (PLAY_REQ === 1'b1) ids.push_back(PLAY_ID);
  wss_top DUT (.SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .EXT_SLOT_FOUR(ext[0]), .EXT_SLOT_FIVE(ext[1]),
    .EXT_SLOT_SIX(ext[2]), .EXT_SLOT_SEVEN(ext[3]), .PLAY_DONE(PLAY_DONE), .PLAY_ID(PLAY_ID),
    .PLAY_REQ(PLAY_REQ), .PLAY_STOP(PLAY_STOP), .SEQ_ACTIVE(SEQ_ACTIVE));
  wss_engine_model ENG (.clk(SYS_CLK), .rst(RST), .req(PLAY_REQ), .stop(PLAY_STOP), .lat(lat), .done(PLAY_DONE));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge SYS_CLK);
    {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    @(negedge SYS_CLK);
    REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge SYS_CLK);
    {REG_RD, REG_ADDR} = {1'b1, a};
    @(negedge SYS_CLK);
    REG_RD = 1'b0;
    @(negedge SYS_CLK);
    chk("read data", e, REG_RDATA);
  endtask
  // Expected plays: slots in order up to the first zero, eight at most
  task automatic play(input wss_id_t v [8], input logic [7:0] l);
    int k;
    int n;
    k = 0;
    ids = {};
    lat = l;
    for (int i = 0; i < 4; i++) wr(WSS_ADDR_SLOT_ZERO + 8'(i), v[i]);
    for (int i = 0; i < 4; i++) ext[i] = v[i + 4];
    wr(WSS_ADDR_CTRL, 8'h01);
    chk("go set", 8'h01, {7'h00, SEQ_ACTIVE});
    for (n = 0; n < 500 && SEQ_ACTIVE !== 1'b0; n++) @(negedge SYS_CLK);
    while (k < 8 && v[k] != 8'h00) k++;
    chk("plays", 8'(k), 8'(ids.size()));
    for (int i = 0; i < k && i < ids.size(); i++) chk("id", v[i], ids[i]);
    rd(WSS_ADDR_CTRL, 8'h00);
    if (n == 500) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic regs_check();
    for (int i = 0; i < 4; i++) rd(WSS_ADDR_SLOT_ZERO + 8'(i), WSS_SLOT_RESET);
    for (int i = 0; i < 4; i++) wr(WSS_ADDR_SLOT_ZERO + 8'(i), 8'ha5 ^ 8'(i * 65));
    wr(8'h0b, 8'hff);
    for (int i = 0; i < 4; i++) rd(WSS_ADDR_SLOT_ZERO + 8'(i), 8'ha5 ^ 8'(i * 65));
    rd(8'h0b, WSS_READ_ZERO);
  endtask
  task automatic full_walk();
    play('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'hff}, 8'h06);
  endtask
  task automatic zero_mid();
    play('{8'h01, 8'h80, 8'h00, 8'h09, 8'h0a, 8'h00, 8'h00, 8'h00}, 8'h01);
  endtask
  task automatic zero_first();
    play('{8'h00, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48}, 8'h02);
  endtask
  // Writing zero mid waveform stops it and clears the start bit
  task automatic cancel_mid();
    int n;
    ids = {};
    lat = 8'h20;
    wr(WSS_ADDR_SLOT_ZERO, 8'h5a);
    wr(WSS_ADDR_CTRL, 8'h01);
    for (n = 0; n < 50 && ids.size() == 0; n++) @(negedge SYS_CLK);
    chk("stop idle", 8'h00, {7'h00, PLAY_STOP});
    wr(WSS_ADDR_CTRL, 8'h00);
    chk("stop pulse", 8'h01, {7'h00, PLAY_STOP});
    chk("go cancel", 8'h00, {7'h00, SEQ_ACTIVE});
    @(negedge SYS_CLK);
    chk("stop ends", 8'h00, {7'h00, PLAY_STOP});
    chk("cancel plays", 8'h01, 8'(ids.size()));
    if (n == 50) begin
      mismatches++;
      conclude();
    end
  endtask
  initial begin
    repeat (12) @(negedge SYS_CLK);
    RST = 1'b0;
    regs_check();
    full_walk();
    zero_mid();
    zero_first();
    cancel_mid();
    conclude();
  end
endmodule
